// File: rtl/dpd_pkg.sv
// constants, encodings and state types of the dual port cycle dispatch
// assumes one clock at 200 mhz; all cycle counts are derived from it
package dpd_pkg;
    localparam int ADDR_W = 30;                 // word address, bits 31:2
    localparam int BE_W = 4;
    localparam int DEF_W = 3;                   // {mem/io, data/code, write/read}
    localparam int DEF_MIO_POS = 2;
    localparam int DEF_WR_POS = 0;
    localparam int LEN_W = 3;
    localparam int POP_N = 4;
    localparam int POP_W = 8;                   // bank size in 1 MB units
    localparam int POP_IDX_W = 2;
    localparam logic [POP_W-1:0] POP_RST = 8'h00;
    localparam int MB_SHIFT = 18;               // 1 MB expressed in words
    localparam int ROW_LSB = 9;
    localparam int SYNC_N = 3;

    localparam logic [LEN_W-1:0] LEN_PAGE_HIT = 3'h1;
    localparam logic [LEN_W-1:0] LEN_PAGE_MISS = 3'h3;
    localparam logic [LEN_W-1:0] LEN_NONDET = 3'h7;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int SNOOP_HOLD_NS = 20;
    localparam int SNOOP_HOLD_CYC =
        (SNOOP_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SNOOP_CNT_W = 3;

    typedef enum logic [2:0] {
        DPD_H_IDLE = 3'b000,
        DPD_H_DRAM = 3'b001,
        DPD_H_FWD = 3'b010,
        DPD_H_FWD_WAIT = 3'b011,
        DPD_H_END = 3'b100
    } dpd_host_st_t;

    typedef enum logic [2:0] {
        DPD_S_IDLE = 3'b000,
        DPD_S_REQ = 3'b001,
        DPD_S_DRAM = 3'b010,
        DPD_S_SNOOP = 3'b011,
        DPD_S_END = 3'b100
    } dpd_sys_st_t;
endpackage

// File: rtl/dpd_dec_if.sv
// carrier between the dispatcher and its address decoders
// assumes the decoder answers in the same cycle (pure logic)
`timescale 1ns/1ps
interface dpd_dec_if;
    import dpd_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DEF_W-1:0] def;
    logic [POP_N*POP_W-1:0] pop;
    logic in_mem;
    logic [ADDR_W-ROW_LSB-1:0] row;
    modport client (output addr, output def, output pop, input in_mem, input row);
    modport decoder (input addr, input def, input pop, output in_mem, output row);
endinterface

// File: rtl/dpd_decode.sv
// main memory decode from the four bank population values
// assumes the bank values are packed from bank 0 upward
`timescale 1ns/1ps
module dpd_decode
    import dpd_pkg::*;
(
    dpd_dec_if.decoder dec
);
    // ----------------------------------------
    // top of populated memory
    // ----------------------------------------
    function automatic logic [ADDR_W-1:0] top_of_mem(input logic [POP_N*POP_W-1:0] pop);
        logic [ADDR_W-1:0] sum;
        sum = '0;
        for (int i = 0; i < POP_N; i++) begin
            sum = sum + (ADDR_W'(pop[i*POP_W +: POP_W]) << MB_SHIFT);
        end
        return sum;
    endfunction

    // io space never hits memory
    assign dec.in_mem = dec.def[DEF_MIO_POS] && (dec.addr < top_of_mem(dec.pop));
    assign dec.row = dec.addr[ADDR_W-1:ROW_LSB];
endmodule

// File: rtl/dpd_dispatch.sv
// cycle dispatch of a dual ported dram controller: host and system port
// assumes strobes from the far side are asynchronous; dram engine on clk_sys
//
// How it works
// RL1: host cycle decoded to dram or system bus unless it targets memory while grant_lvl is high
// RL2: host port only receives; drives snoop addresses
// RL3: system port sends and receives address, definition
// RL4: system cycle in memory runs dram, else ignored
// RL5: host-to-system cycles forwarded to expansion controller
// RL6: handshakes clockless; no processor clock used
// RL7: return 3-bit cycle length code at start
// RL8: converter turns processor strobes into start, type
// RL9: standard or buffered system side mode
// RL10: four population registers written by boot software
// RL11: strobe fall latches cycle, rise ends it
// RL12: ready deasserted during forwarded and locked cycles
// RL13: memory ownership requested, owned after grant
`timescale 1ns/1ps
module dpd_dispatch
    import dpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic host_as_n,
    input wire logic [ADDR_W-1:0] host_addr_in,
    output logic [ADDR_W-1:0] host_addr_out,
    output logic host_addr_oe,
    input wire logic [BE_W-1:0] host_be_n,
    input wire logic [DEF_W-1:0] host_def,
    input wire logic host_lock_n,
    output logic host_async_ready,
    output logic [LEN_W-1:0] host_cycle_len,
    output logic host_snoop_strobe,
    output logic host_side_memory_request,
    input wire logic host_side_memory_grant,
    input wire logic sys_buffered,
    input wire logic sys_as_n,
    input wire logic [ADDR_W-1:0] sys_addr_in,
    input wire logic [DEF_W-1:0] sys_def_in,
    output logic [ADDR_W-1:0] sys_addr_out,
    output logic sys_addr_oe,
    output logic [DEF_W-1:0] sys_def_out,
    output logic [BE_W-1:0] sys_be_n_out,
    output logic sys_fwd_start,
    output logic sys_fwd_as_n,
    input wire logic sys_fwd_done,
    output logic sys_mem_ready,
    input wire logic refresh_req,
    output logic refresh_owned,
    input wire logic pop_wr_en,
    input wire logic [POP_IDX_W-1:0] pop_wr_idx,
    input wire logic [POP_W-1:0] pop_wr_data,
    output logic [POP_N*POP_W-1:0] pop_value,
    output logic dram_start,
    output logic [ADDR_W-1:0] dram_addr,
    output logic dram_write,
    output logic dram_from_sys,
    input wire logic dram_done
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // clockless far side: every strobe is resampled here
    logic [SYNC_N-1:0] has_sync, sas_sync, done_sync, grant_sync;
    logic has_lvl, sas_lvl, done_lvl, grant_lvl;
    logic has_prev, sas_prev;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            has_sync <= '1;
            sas_sync <= '1;
            done_sync <= '0;
            grant_sync <= '0;
        end else begin
            has_sync <= {has_sync[SYNC_N-2:0], host_as_n}; // RL6
            sas_sync <= {sas_sync[SYNC_N-2:0], sys_as_n};
            done_sync <= {done_sync[SYNC_N-2:0], sys_fwd_done};
            grant_sync <= {grant_sync[SYNC_N-2:0], host_side_memory_grant};
        end
    end

    // a level changes only once the last two stages agree
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            has_lvl <= 1'b1;
            sas_lvl <= 1'b1;
            done_lvl <= 1'b0;
            grant_lvl <= 1'b0;
            has_prev <= 1'b1;
            sas_prev <= 1'b1;
        end else begin
            if (has_sync[1] == has_sync[2]) has_lvl <= has_sync[2];
            if (sas_sync[1] == sas_sync[2]) sas_lvl <= sas_sync[2];
            if (done_sync[1] == done_sync[2]) done_lvl <= done_sync[2];
            if (grant_sync[1] == grant_sync[2]) grant_lvl <= grant_sync[2];
            has_prev <= has_lvl;
            sas_prev <= sas_lvl;
        end
    end

    logic host_start, host_end, sys_start, sys_end;
    assign host_start = has_prev && !has_lvl; // RL11
    assign host_end = !has_prev && has_lvl; // RL11
    assign sys_start = sas_prev && !sas_lvl;
    assign sys_end = !sas_prev && sas_lvl;

    // ----------------------------------------
    // population registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pop_value <= {POP_N{POP_RST}};
        end else if (pop_wr_en) begin
            pop_value[pop_wr_idx*POP_W +: POP_W] <= pop_wr_data; // RL10
        end
    end

    // ----------------------------------------
    // host latch and decode
    // ----------------------------------------
    logic [ADDR_W-1:0] h_addr;
    logic [BE_W-1:0] h_be_n;
    logic [DEF_W-1:0] h_def;
    logic h_lock;
    logic [ADDR_W-1:0] s_addr;
    logic [DEF_W-1:0] s_def;
    logic [ADDR_W-ROW_LSB-1:0] open_row;
    logic row_valid;

    // latch is open while the strobe is high, closes at its fall
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            h_addr <= '0;
            h_be_n <= '1;
            h_def <= '0;
            h_lock <= 1'b0;
        end else if (has_lvl && !host_start) begin
            h_addr <= host_addr_in; // RL11
            h_be_n <= host_be_n;
            h_def <= host_def;
            h_lock <= !host_lock_n;
        end
    end

    dpd_dec_if hdec ();
    dpd_dec_if sdec ();
    assign hdec.addr = h_addr;
    assign hdec.def = h_def;
    assign hdec.pop = pop_value;
    assign sdec.addr = s_addr;
    assign sdec.def = s_def;
    assign sdec.pop = pop_value;

    dpd_decode u_host_dec (.dec(hdec.decoder));
    dpd_decode u_sys_dec (.dec(sdec.decoder));

    // ----------------------------------------
    // host state machine
    // ----------------------------------------
    dpd_host_st_t h_st;
    dpd_sys_st_t s_st;
    logic fwd_busy;
    assign fwd_busy = (s_st != DPD_S_IDLE);

    // host owns memory unless the converter has granted it to this side
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            h_st <= DPD_H_IDLE;
            host_cycle_len <= LEN_NONDET;
            host_async_ready <= 1'b1;
            row_valid <= 1'b0;
            open_row <= '0;
        end else begin
            case (h_st)
                DPD_H_IDLE: begin
                    if (host_start) begin
                        if (hdec.in_mem && !grant_lvl) begin // RL1
                            host_cycle_len <= (row_valid && open_row == hdec.row) ?
                                LEN_PAGE_HIT : LEN_PAGE_MISS; // RL7
                            host_async_ready <= !h_lock; // RL12
                            open_row <= hdec.row;
                            row_valid <= 1'b1;
                            h_st <= DPD_H_DRAM;
                        end else if (!hdec.in_mem) begin
                            host_cycle_len <= LEN_NONDET; // RL7
                            host_async_ready <= 1'b0; // RL12
                            h_st <= DPD_H_FWD;
                        end
                    end
                end
                DPD_H_DRAM: begin
                    if (dram_done) begin
                        host_async_ready <= 1'b1;
                        h_st <= DPD_H_END;
                    end
                end
                DPD_H_FWD: begin
                    if (!fwd_busy && !done_lvl) h_st <= DPD_H_FWD_WAIT; // RL5
                end
                DPD_H_FWD_WAIT: begin
                    if (done_lvl) begin
                        host_async_ready <= 1'b1; // RL12
                        h_st <= DPD_H_END;
                    end
                end
                DPD_H_END: begin
                    if (host_end || has_lvl) h_st <= DPD_H_IDLE; // RL11
                end
                default: h_st <= DPD_H_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // forwarding to the expansion controller
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sys_fwd_start <= 1'b0;
            sys_fwd_as_n <= 1'b1;
            sys_addr_out <= '0;
            sys_def_out <= '0;
            sys_be_n_out <= '1;
        end else begin
            sys_fwd_start <= (h_st == DPD_H_FWD) && !fwd_busy && !done_lvl; // RL5
            if (h_st == DPD_H_FWD && !fwd_busy) begin
                sys_addr_out <= h_addr; // RL3
                sys_def_out <= h_def;
                sys_be_n_out <= h_be_n;
            end
            // buffered mode: intermediate bus carries a host-like strobe
            sys_fwd_as_n <= !(sys_buffered && h_st == DPD_H_FWD_WAIT); // RL9
        end
    end

    // standard mode drives the expansion address lines directly
    assign sys_addr_oe = (h_st == DPD_H_FWD_WAIT); // RL9

    // ----------------------------------------
    // system port state machine
    // ----------------------------------------
    logic [SNOOP_CNT_W-1:0] snoop_cnt;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_st <= DPD_S_IDLE;
            s_addr <= '0;
            s_def <= '0;
            sys_mem_ready <= 1'b0;
            snoop_cnt <= '0;
        end else begin
            case (s_st)
                DPD_S_IDLE: begin
                    sys_mem_ready <= 1'b0;
                    if (sys_start && h_st != DPD_H_FWD_WAIT) begin
                        s_addr <= sys_addr_in; // RL3
                        s_def <= sys_def_in;
                        s_st <= DPD_S_REQ;
                    end
                end
                DPD_S_REQ: begin
                    // only a host dram cycle holds this off: a host forward waits on us
                    if (!sdec.in_mem) s_st <= DPD_S_END; // RL4
                    else if (grant_lvl && h_st != DPD_H_DRAM) s_st <= DPD_S_DRAM; // RL13
                end
                DPD_S_DRAM: begin
                    if (dram_done) begin
                        sys_mem_ready <= 1'b1; // RL4
                        snoop_cnt <= SNOOP_CNT_W'(SNOOP_HOLD_CYC);
                        s_st <= s_def[DEF_WR_POS] ? DPD_S_SNOOP : DPD_S_END;
                    end
                end
                DPD_S_SNOOP: begin
                    if (snoop_cnt == '0) s_st <= DPD_S_END;
                    else snoop_cnt <= snoop_cnt - 1'b1;
                end
                DPD_S_END: begin
                    if (sys_end || sas_lvl) s_st <= DPD_S_IDLE;
                end
                default: s_st <= DPD_S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // ownership, dram launch and snoop drive
    // ----------------------------------------
    // refresh and system masters share one request toward the converter
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            host_side_memory_request <= 1'b0;
        end else begin
            host_side_memory_request <= refresh_req ||
                (s_st == DPD_S_REQ && sdec.in_mem) || s_st == DPD_S_DRAM; // RL13
        end
    end

    assign refresh_owned = refresh_req && grant_lvl && s_st != DPD_S_DRAM; // RL13

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dram_start <= 1'b0;
            dram_addr <= '0;
            dram_write <= 1'b0;
            dram_from_sys <= 1'b0;
        end else begin
            dram_start <= 1'b0;
            if (h_st == DPD_H_IDLE && host_start && hdec.in_mem && !grant_lvl) begin
                dram_start <= 1'b1; // RL1
                dram_addr <= h_addr;
                dram_write <= h_def[DEF_WR_POS];
                dram_from_sys <= 1'b0;
            end else if (s_st == DPD_S_REQ && sdec.in_mem && grant_lvl
                         && h_st != DPD_H_DRAM) begin
                dram_start <= 1'b1; // RL4
                dram_addr <= s_addr;
                dram_write <= s_def[DEF_WR_POS];
                dram_from_sys <= 1'b1;
            end
        end
    end

    // host address lines are driven only for invalidation addresses
    assign host_addr_oe = (s_st == DPD_S_SNOOP); // RL2
    assign host_addr_out = s_addr;
    assign host_snoop_strobe = (s_st == DPD_S_SNOOP);
endmodule

// File: tb/dpd_chk.sv
// assertions on the dispatch top ports
// assumes one clock and the synchronous active low reset
`timescale 1ns/1ps
module dpd_chk
    import dpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sys_buffered,
    input wire logic refresh_req,
    input wire logic host_side_memory_grant,
    input wire logic dram_done,
    input wire logic host_async_ready,
    input wire logic [LEN_W-1:0] host_cycle_len,
    input wire logic host_addr_oe,
    input wire logic host_snoop_strobe,
    input wire logic host_side_memory_request,
    input wire logic refresh_owned,
    input wire logic sys_fwd_start,
    input wire logic sys_fwd_as_n,
    input wire logic sys_mem_ready,
    input wire logic dram_start,
    input wire logic dram_from_sys
);
    // ---
    // port relations
    // ---
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_fwd_go;
        sys_fwd_start;
    endsequence
    sequence s_sys_dram;
        dram_start && dram_from_sys;
    endsequence
    sequence s_snoop_run;
        host_addr_oe [*5] ##1 !host_addr_oe;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> host_async_ready
        && host_cycle_len == LEN_NONDET && !host_side_memory_request)
        else $error("outputs not quiet after reset");
    a_fwd_nondet_len: assert property (s_fwd_go |-> host_cycle_len == LEN_NONDET
        && !host_async_ready) else $error("forward not marked non-deterministic");
    a_fwd_one_pulse: assert property (s_fwd_go |=> !sys_fwd_start)
        else $error("forward start too long");
    a_dram_one_pulse: assert property (dram_start |=> !dram_start)
        else $error("dram start too long");
    a_snoop_drive_pair: assert property (host_addr_oe |-> host_snoop_strobe
        && sys_mem_ready) else $error("snoop address without strobe");
    a_snoop_len: assert property ($rose(host_addr_oe) |-> s_snoop_run)
        else $error("snoop drive length wrong");
    a_refresh_owned_grant: assert property (refresh_owned |-> refresh_req
        && host_side_memory_grant) else $error("refresh owns memory without grant");
    a_sys_dram_owned: assert property (s_sys_dram |-> host_side_memory_request)
        else $error("system dram cycle without request");
    a_mem_ready_cause: assert property ($rose(sys_mem_ready) |-> $past(dram_done))
        else $error("system ready without dram done");
    a_std_no_strobe: assert property (!sys_buffered |-> sys_fwd_as_n)
        else $error("forward strobe in standard mode");
endmodule
bind dpd_dispatch dpd_chk chk_u (.*);

// File: tb/dpd_far_end.sv
// far side model: converter grant, expansion controller, dram engine
// assumes the dispatch clock; slow stretches every answer
`timescale 1ns/1ps
module dpd_far_end (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic host_side_memory_request,
    input wire logic sys_fwd_start,
    input wire logic sys_addr_oe,
    input wire logic dram_start,
    output logic host_side_memory_grant,
    output logic sys_fwd_done,
    output logic dram_done
);
    // ---
    // answer timers
    // ---
    logic [3:0] g_cnt, f_cnt, d_cnt, dly;
    assign dly = slow ? 4'h7 : 4'h1;
    // grant only while the request stands, never ahead of it
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !host_side_memory_request) begin
            g_cnt <= 4'h0;
            host_side_memory_grant <= 1'b0;
        end else if (g_cnt < dly) begin
            g_cnt <= g_cnt + 4'h1;
        end else begin
            host_side_memory_grant <= 1'b1;
        end
    end
    // done is a level, dropped once the forward address is released
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            f_cnt <= 4'h0;
            sys_fwd_done <= 1'b0;
        end else if (sys_fwd_start) begin
            f_cnt <= dly + 4'h1;
        end else if (f_cnt == 4'h1) begin
            f_cnt <= 4'h0;
            sys_fwd_done <= 1'b1;
        end else if (f_cnt != 4'h0) begin
            f_cnt <= f_cnt - 4'h1;
        end else if (!sys_addr_oe) begin
            sys_fwd_done <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            d_cnt <= 4'h0;
            dram_done <= 1'b0;
        end else begin
            dram_done <= (d_cnt == 4'h1);
            if (dram_start) begin
                d_cnt <= dly + 4'h2;
            end else if (d_cnt != 4'h0) begin
                d_cnt <= d_cnt - 4'h1;
            end
        end
    end
endmodule

// File: tb/dpd_dispatch_test.sv
// self-checking bench of the dual port cycle dispatch
// assumes the far side model answers grants, forwards and dram cycles
`timescale 1ns/1ps
module dpd_dispatch_test;
    import dpd_pkg::*;
    // banks 1, 2, 0, 1 mb: main memory is 4 mb of words
    localparam logic [31:0] BANKS = 32'h01000201;
    localparam int MEM_WORDS = 4 << MB_SHIFT;
    logic clk_sys, rst_n, host_as_n, host_lock_n, sys_buffered, sys_as_n, refresh_req;
    logic pop_wr_en, slow, host_side_memory_grant, sys_fwd_done, dram_done;
    logic [ADDR_W-1:0] host_addr_in, sys_addr_in, host_addr_out, sys_addr_out, dram_addr;
    logic [DEF_W-1:0] host_def, sys_def_in, sys_def_out;
    logic [BE_W-1:0] host_be_n, sys_be_n_out;
    logic [LEN_W-1:0] host_cycle_len;
    logic [POP_IDX_W-1:0] pop_wr_idx;
    logic [POP_W-1:0] pop_wr_data;
    logic [POP_N*POP_W-1:0] pop_value;
    logic host_addr_oe, host_async_ready, host_snoop_strobe, host_side_memory_request;
    logic sys_addr_oe, sys_fwd_start, sys_fwd_as_n, sys_mem_ready, refresh_owned;
    logic dram_start, dram_write, dram_from_sys, hit;
    logic [ADDR_W-ROW_LSB-1:0] last_row;
    int n_fail, n_tests, i;
    dpd_dispatch dut_u (.*);
    dpd_far_end far_u (.*);
    // ---
    // helpers
    // ---
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_hi(ref logic s, output logic h);
        h = 1'b0;
        for (int k = 0; k < 80 && !h; k++) begin
            @(negedge clk_sys);
            h = (s === 1'b1);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // memory is the mem/io bit set and a word below the populated top
    function automatic logic mem_hit(input logic [ADDR_W-1:0] a, input logic [DEF_W-1:0] d);
        return d[DEF_MIO_POS] && (a < MEM_WORDS);
    endfunction
    // strobe held low until ready, as the converter would
    task automatic host_cyc(input logic [ADDR_W-1:0] a, input logic [DEF_W-1:0] d,
                            input logic lk_n);
        logic [BE_W-1:0] be;
        be = 4'($urandom);
        @(posedge clk_sys);
        host_addr_in <= a;
        host_be_n <= be;
        host_def <= d;
        host_lock_n <= lk_n;
        @(posedge clk_sys);
        host_as_n <= 1'b0;
        if (mem_hit(a, d)) begin
            wait_hi(dram_start, hit);
            chk("host dram", {hit, d[DEF_WR_POS], a}, {1'b1, dram_write, dram_addr});
            chk("host source", 0, dram_from_sys);
            chk("length", (a[ADDR_W-1:ROW_LSB] === last_row) ? LEN_PAGE_HIT : LEN_PAGE_MISS,
                host_cycle_len);
            if (!lk_n) chk("locked ready", 0, host_async_ready);
            last_row = a[ADDR_W-1:ROW_LSB];
            wait_hi(dram_done, hit);
        end else begin
            wait_hi(sys_fwd_start, hit);
            chk("forward", {hit, d, a}, {1'b1, sys_def_out, sys_addr_out});
            chk("nondet length", LEN_NONDET, host_cycle_len);
            chk("forward be", be, sys_be_n_out);
            @(negedge clk_sys);
            chk("fwd strobe", !sys_buffered, sys_fwd_as_n);
            chk("fwd drive", 2, {sys_addr_oe, host_async_ready});
        end
        wait_hi(host_async_ready, hit);
        chk("ready back", 1, hit);
        @(posedge clk_sys);
        host_as_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic sys_cyc(input logic [ADDR_W-1:0] a, input logic [DEF_W-1:0] d);
        @(posedge clk_sys);
        sys_addr_in <= a;
        sys_def_in <= d;
        @(posedge clk_sys);
        sys_as_n <= 1'b0;
        wait_hi(dram_start, hit);
        if (mem_hit(a, d)) begin
            chk("sys dram", {1'b1, a}, {hit & dram_from_sys, dram_addr});
            wait_hi(sys_mem_ready, hit);
            chk("sys ready", 1, hit);
            if (d[DEF_WR_POS]) begin
                wait_hi(host_addr_oe, hit);
                chk("snoop", {1'b1, a}, {hit, host_addr_out});
            end
        end else begin
            chk("sys ignored", 0, hit | host_side_memory_request);
        end
        @(posedge clk_sys);
        sys_as_n <= 1'b1;
        repeat (12) @(posedge clk_sys);
    endtask
    // ---
    // sequence
    // ---
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end
    initial begin
        {n_fail, n_tests} = 0;
        {rst_n, pop_wr_en, sys_buffered, refresh_req, slow} = 0;
        {host_as_n, host_lock_n, sys_as_n} = 3'h7;
        {host_addr_in, sys_addr_in, host_def, sys_def_in, host_be_n} = 0;
        {pop_wr_idx, pop_wr_data} = 0;
        last_row = 'x;
        void'($urandom(39986));
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        chk("reset", {1'b1, LEN_NONDET, 1'b0},
            {host_async_ready, host_cycle_len, host_side_memory_request});
        for (i = 0; i < POP_N; i++) begin
            @(posedge clk_sys);
            pop_wr_en <= 1'b1;
            pop_wr_idx <= i[1:0];
            pop_wr_data <= BANKS[i*8 +: 8];
        end
        @(posedge clk_sys);
        pop_wr_en <= 1'b0;
        @(negedge clk_sys);
        chk("population", BANKS, pop_value);
        host_cyc(30'h0001234, 3'h4, 1'b1);
        host_cyc(30'h0001330, 3'h5, 1'b1);
        host_cyc(30'h00fffff, 3'h4, 1'b0);
        for (i = 0; i < 2; i++) begin
            sys_buffered <= i[0];
            host_cyc(30'h0100000, 3'h4, 1'b1);
        end
        host_cyc(30'h0000010, 3'h0, 1'b1);
        slow <= 1'b1;
        sys_cyc(30'h0000400, 3'h5);
        sys_cyc(30'h0000404, 3'h4);
        sys_cyc(30'h0100000, 3'h5);
        refresh_req <= 1'b1;
        wait_hi(refresh_owned, hit);
        chk("refresh own", 3, {hit, host_side_memory_request});
        @(posedge clk_sys);
        refresh_req <= 1'b0;
        repeat (12) @(posedge clk_sys);
        for (i = 0; i < 24; i++) begin
            slow <= 1'($urandom);
            host_cyc(30'($urandom_range(0, 30'h1fffff)), 3'($urandom), 1'b1);
            if (i % 3 == 0) sys_cyc(30'($urandom_range(0, 30'h1fffff)), 3'($urandom));
        end
        complete_run();
    end
endmodule
